// ---- suart_dev.sv ----
`timescale 1ns/1ps
`include "suart_regs.svh"
module suart_dev (
  // Clock, reset and clock enable.
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Link.
  suart_if.dev link,
  // Configuration.
  input wire logic [1:0] mode_selection_field_in,
  input wire logic clk_out_mode_in,
  input wire logic receive_enable_bit_in,
  input wire logic transmit_enable_in,
  input wire logic double_buffer_select_in,
  input wire logic parity_enable_bit_in,
  input wire logic parity_even_in,
  input wire logic stop_length_setting_in,
  input wire logic wake_up_bit_in,
  input wire logic transmit_ninth_bit_in,
  // Transmit data into the FIFO.
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out,
  // Receive buffer.
  input wire logic rx_read_in,
  output logic [7:0] rx_data_out,
  output logic receive_ninth_bit_out,
  // Status and events.
  output logic receive_buffer_full_flag_out,
  output logic transmit_buffer_empty_flag_out,
  output logic receive_interrupt_out,
  output logic transmit_interrupt_out,
  output logic overrun_out,
  output logic underrun_out,
  output logic parity_err_out,
  output logic framing_err_out
);
  logic sclk_s1_r, sclk_s2_r, sclk_s3_r, rxd_s1_r, rxd_s2_r;
  logic fifo_valid, pop;
  logic [8:0] fifo_data;
  logic [8:0] tbuf_r, tbuf_nxt, tsh_r, tsh_nxt, rbuf_r, rbuf_nxt, rsh_r, rsh_nxt;
  logic tbuf_full_r, tbuf_full_nxt, tsh_full_r, tsh_full_nxt;
  logic rbuf_full_r, rbuf_full_nxt, pend_r, pend_nxt;
  logic [11:0] ser_r, ser_nxt;
  logic txd_r, txd_nxt, sclk_r, sclk_nxt, io_act_r, io_act_nxt, txa_r, txa_nxt;
  logic [3:0] cnt_r, cnt_nxt, tcnt_r, tcnt_nxt, rcnt_r, rcnt_nxt;
  logic [15:0] div_r, div_nxt, tdiv_r, tdiv_nxt, rdiv_r, rdiv_nxt;
  suart_pkg::suart_rx_e rst_r, rst_nxt;
  logic rxirq_r, rxirq_nxt, txirq_r, txirq_nxt, ovr_r, ovr_nxt, udr_r, udr_nxt;
  logic perr_r, perr_nxt, ferr_r, ferr_nxt;

  assign pop = !tbuf_full_r;

  suart_fifo #(.W(9), .D(`SUART_FIFO_DEPTH)) u_fifo (
    .clk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .in_valid_in(tx_valid_in),
    .in_data_in({transmit_ninth_bit_in, tx_data_in}),
    .in_ready_out(tx_ready_out),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_data),
    .out_ready_in(pop)
  );

  // The shift clock and receive line come from the far end's clock domain.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sclk_s1_r <= 1'b1;
      sclk_s2_r <= 1'b1;
      sclk_s3_r <= 1'b1;
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
    end else if (ce_in) begin
      sclk_s1_r <= link.sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      rxd_s1_r <= link.host_txd;
      rxd_s2_r <= rxd_s1_r;
    end
  end

  always_comb begin
    logic io, dbl, receive_enable_bit, txe, have_tx, rx_ok, rfull, fall, rise;
    logic [8:0] txw;
    logic [11:0] frm;
    logic [9:0] dec;
    logic [3:0] plen;
    io = mode_selection_field_in == `SUART_MODE_IO;
    dbl = double_buffer_select_in;
    receive_enable_bit = receive_enable_bit_in;
    txe = transmit_enable_in;
    have_tx = dbl ? tsh_full_r : tbuf_full_r;
    txw = dbl ? tsh_r : tbuf_r;
    // Parity is ignored in nine-bit mode by the frame builder.
    frm = suart_pkg::suart_frame(mode_selection_field_in, parity_enable_bit_in,
                                 parity_even_in, txw);
    plen = suart_pkg::suart_pay_len(mode_selection_field_in, parity_enable_bit_in);
    dec = suart_pkg::suart_decode(mode_selection_field_in, parity_enable_bit_in,
                                  parity_even_in, rsh_r);
    rfull = rbuf_full_r && !rx_read_in;
    rx_ok = !receive_enable_bit || ((dbl && !txe) ? !pend_r : (!rbuf_full_r && !pend_r));
    fall = sclk_s3_r && !sclk_s2_r;
    rise = !sclk_s3_r && sclk_s2_r;
    tbuf_nxt = tbuf_r;
    tbuf_full_nxt = tbuf_full_r;
    tsh_nxt = tsh_r;
    tsh_full_nxt = tsh_full_r;
    rbuf_nxt = rbuf_r;
    rbuf_full_nxt = rbuf_full_r;
    rsh_nxt = rsh_r;
    pend_nxt = pend_r;
    ser_nxt = ser_r;
    txd_nxt = txd_r;
    sclk_nxt = sclk_r;
    io_act_nxt = io_act_r;
    txa_nxt = txa_r;
    cnt_nxt = cnt_r;
    tcnt_nxt = tcnt_r;
    rcnt_nxt = rcnt_r;
    div_nxt = div_r;
    tdiv_nxt = tdiv_r;
    rdiv_nxt = rdiv_r;
    rst_nxt = rst_r;
    rxirq_nxt = 1'b0;
    txirq_nxt = 1'b0;
    ovr_nxt = 1'b0;
    udr_nxt = 1'b0;
    perr_nxt = 1'b0;
    ferr_nxt = 1'b0;
    if (rx_read_in) begin
      rbuf_full_nxt = 1'b0;
      if (pend_r) begin
        rbuf_nxt = {1'b0, rsh_r[8:1]};
        rbuf_full_nxt = 1'b1;
        pend_nxt = 1'b0;
        rxirq_nxt = 1'b1;
      end
    end
    if (pop && fifo_valid) begin
      tbuf_nxt = fifo_data;
      tbuf_full_nxt = 1'b1;
    end
    if (dbl && tbuf_full_r && !tsh_full_r) begin
      tsh_nxt = tbuf_r;
      tsh_full_nxt = 1'b1;
      tbuf_full_nxt = 1'b0;
      txirq_nxt = 1'b1;
    end
    if (clk_out_mode_in) begin
      fall = 1'b0;
      rise = 1'b0;
      if (io_act_r) begin
        if (div_r == `SUART_SCLK_HALF - 16'h0001) begin
          div_nxt = 16'h0000;
          sclk_nxt = !sclk_r;
          fall = sclk_r;
          rise = !sclk_r;
        end else begin
          div_nxt = div_r + 16'h0001;
        end
      end
    end
    if (io && !io_act_r) begin
      // The line returns to idle one cycle after the last edge, never on a sampling edge.
      txd_nxt = 1'b1;
      if (clk_out_mode_in ? ((receive_enable_bit || txe) && (!txe || have_tx) && rx_ok)
                          : (fall && (receive_enable_bit || txe))) begin
        io_act_nxt = 1'b1;
        cnt_nxt = 4'h0;
        div_nxt = 16'h0000;
        sclk_nxt = 1'b1;
        ser_nxt = {4'hf, `SUART_DUMMY};
        if (txe && have_tx) begin
          ser_nxt = {4'hf, txw[7:0]};
          tbuf_full_nxt = dbl ? tbuf_full_nxt : 1'b0;
          tsh_full_nxt = dbl ? 1'b0 : tsh_full_nxt;
        end else if (txe) begin
          udr_nxt = 1'b1;
        end
        txd_nxt = ser_nxt[0];
      end
    end else if (io) begin
      if (fall && cnt_r != 4'h0) begin
        ser_nxt = {1'b1, ser_r[11:1]};
        txd_nxt = ser_r[1];
      end
      if (rise) begin
        rsh_nxt = {rxd_s2_r, rsh_r[8:1]};
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == `SUART_IO_BITS - 4'h1) begin
          io_act_nxt = 1'b0;
          txirq_nxt = txirq_nxt || (txe && !dbl);
          if (receive_enable_bit) begin
            if ((!dbl && clk_out_mode_in) || !rfull) begin
              rbuf_nxt = {1'b0, rxd_s2_r, rsh_r[8:2]};
              rbuf_full_nxt = 1'b1;
              rxirq_nxt = 1'b1;
            end else if (clk_out_mode_in) begin
              pend_nxt = 1'b1;
            end else begin
              ovr_nxt = 1'b1;
            end
          end
        end
      end
    end
    if (!io && !txa_r && txe && have_tx) begin
      txa_nxt = 1'b1;
      ser_nxt = frm;
      txd_nxt = frm[0];
      tcnt_nxt = 4'h0;
      tdiv_nxt = 16'h0000;
      tbuf_full_nxt = dbl ? tbuf_full_nxt : 1'b0;
      tsh_full_nxt = dbl ? 1'b0 : tsh_full_nxt;
    end else if (!io && txa_r) begin
      if (tdiv_r == `SUART_BIT_CYC - 16'h0001) begin
        tdiv_nxt = 16'h0000;
        ser_nxt = {1'b1, ser_r[11:1]};
        txd_nxt = ser_r[1];
        tcnt_nxt = tcnt_r + 4'h1;
        txirq_nxt = txirq_nxt || (!dbl && tcnt_r == plen);
        if (tcnt_r == plen + 4'h1 + {3'h0, stop_length_setting_in}) begin
          txa_nxt = 1'b0;
        end
      end else begin
        tdiv_nxt = tdiv_r + 16'h0001;
      end
    end
    rdiv_nxt = rdiv_r + 16'h0001;
    unique case (rst_r)
      suart_pkg::SUART_RX_IDLE: begin
        rdiv_nxt = 16'h0000;
        if (!io && receive_enable_bit && !rxd_s2_r) begin
          rst_nxt = suart_pkg::SUART_RX_START;
        end
      end
      suart_pkg::SUART_RX_START: begin
        if (rdiv_r == `SUART_HALF_BIT - 16'h0001) begin
          rdiv_nxt = 16'h0000;
          rcnt_nxt = 4'h0;
          rst_nxt = rxd_s2_r ? suart_pkg::SUART_RX_IDLE : suart_pkg::SUART_RX_BITS;
        end
      end
      suart_pkg::SUART_RX_BITS: begin
        if (rdiv_r == `SUART_BIT_CYC - 16'h0001) begin
          rdiv_nxt = 16'h0000;
          rsh_nxt = {rxd_s2_r, rsh_r[8:1]};
          rcnt_nxt = rcnt_r + 4'h1;
          if (rcnt_r == plen - 4'h1) begin
            rst_nxt = suart_pkg::SUART_RX_STOP;
          end
        end
      end
      suart_pkg::SUART_RX_STOP: begin
        if (rdiv_r == `SUART_BIT_CYC - 16'h0001) begin
          rst_nxt = suart_pkg::SUART_RX_IDLE;
          ferr_nxt = !rxd_s2_r;
          perr_nxt = dec[9];
          if (!(mode_selection_field_in == `SUART_MODE_U9 && wake_up_bit_in && !dec[8])) begin
            if (rfull) begin
              ovr_nxt = 1'b1;
            end else begin
              rbuf_nxt = dec[8:0];
              rbuf_full_nxt = 1'b1;
              rxirq_nxt = 1'b1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      tbuf_r <= 9'h000;
      tsh_r <= 9'h000;
      rbuf_r <= 9'h000;
      rsh_r <= 9'h000;
      tbuf_full_r <= 1'b0;
      tsh_full_r <= 1'b0;
      rbuf_full_r <= 1'b0;
      pend_r <= 1'b0;
      ser_r <= 12'hfff;
      txd_r <= 1'b1;
      sclk_r <= 1'b1;
      io_act_r <= 1'b0;
      txa_r <= 1'b0;
      cnt_r <= 4'h0;
      tcnt_r <= 4'h0;
      rcnt_r <= 4'h0;
      div_r <= 16'h0000;
      tdiv_r <= 16'h0000;
      rdiv_r <= 16'h0000;
      rst_r <= suart_pkg::SUART_RX_IDLE;
      rxirq_r <= 1'b0;
      txirq_r <= 1'b0;
      ovr_r <= 1'b0;
      udr_r <= 1'b0;
      perr_r <= 1'b0;
      ferr_r <= 1'b0;
    end else if (ce_in) begin
      tbuf_r <= tbuf_nxt;
      tsh_r <= tsh_nxt;
      rbuf_r <= rbuf_nxt;
      rsh_r <= rsh_nxt;
      tbuf_full_r <= tbuf_full_nxt;
      tsh_full_r <= tsh_full_nxt;
      rbuf_full_r <= rbuf_full_nxt;
      pend_r <= pend_nxt;
      ser_r <= ser_nxt;
      txd_r <= txd_nxt;
      sclk_r <= sclk_nxt;
      io_act_r <= io_act_nxt;
      txa_r <= txa_nxt;
      cnt_r <= cnt_nxt;
      tcnt_r <= tcnt_nxt;
      rcnt_r <= rcnt_nxt;
      div_r <= div_nxt;
      tdiv_r <= tdiv_nxt;
      rdiv_r <= rdiv_nxt;
      rst_r <= rst_nxt;
      rxirq_r <= rxirq_nxt;
      txirq_r <= txirq_nxt;
      ovr_r <= ovr_nxt;
      udr_r <= udr_nxt;
      perr_r <= perr_nxt;
      ferr_r <= ferr_nxt;
    end
  end

  assign link.dev_txd = txd_r;
  assign link.sclk_dev_o = sclk_r;
  assign link.sclk_dev_oe = clk_out_mode_in && mode_selection_field_in == `SUART_MODE_IO;
  assign rx_data_out = rbuf_r[7:0];
  assign receive_ninth_bit_out = rbuf_r[8];
  assign receive_buffer_full_flag_out = rbuf_full_r;
  assign transmit_buffer_empty_flag_out = !tbuf_full_r;
  assign receive_interrupt_out = rxirq_r;
  assign transmit_interrupt_out = txirq_r;
  assign overrun_out = ovr_r;
  assign underrun_out = udr_r;
  assign parity_err_out = perr_r;
  assign framing_err_out = ferr_r;
endmodule

// ---- suart_regs.svh ----
`ifndef SUART_REGS_SVH
`define SUART_REGS_SVH
// Mode selection field codes.
`define SUART_MODE_IO 2'h0
`define SUART_MODE_U7 2'h1
`define SUART_MODE_U8 2'h2
`define SUART_MODE_U9 2'h3
// Bits per I/O interface frame and the filler sent on underrun.
`define SUART_IO_BITS 4'h8
`define SUART_DUMMY 8'hff
// Half period of the shift clock made by each end, in mclk cycles.
`define SUART_SCLK_HALF 16'h0010
`define SUART_HOST_HALF 16'h000c
// Asynchronous bit time and half bit time, in mclk cycles.
`define SUART_BIT_CYC 16'h0040
`define SUART_HALF_BIT 16'h0020
// Transmit FIFO depth.
`define SUART_FIFO_DEPTH 8
`endif

// ---- suart_pkg.sv ----
`include "suart_regs.svh"
package suart_pkg;
  typedef enum logic [1:0] {SUART_RX_IDLE, SUART_RX_START, SUART_RX_BITS, SUART_RX_STOP} suart_rx_e;

  // Bits between start and stop: data plus parity or ninth bit.
  function automatic logic [3:0] suart_pay_len(input logic [1:0] mode, input logic pe);
    if (mode == `SUART_MODE_U7) begin
      suart_pay_len = pe ? 4'h8 : 4'h7;
    end else if (mode == `SUART_MODE_U8) begin
      suart_pay_len = pe ? 4'h9 : 4'h8;
    end else begin
      suart_pay_len = 4'h9;
    end
  endfunction

  // Whole frame, least significant bit first, idle ones above the stop bit.
  function automatic logic [11:0] suart_frame(input logic [1:0] mode, input logic pe,
                                              input logic even, input logic [8:0] w);
    logic par;
    logic ext;
    par = ((mode == `SUART_MODE_U7) ? ^w[6:0] : ^w[7:0]) ^ ~even;
    ext = (mode == `SUART_MODE_U9) ? w[8] : (pe ? par : 1'b1);
    if (mode == `SUART_MODE_U7) begin
      suart_frame = {3'h7, ext, w[6:0], 1'b0};
    end else begin
      suart_frame = {2'h3, ext, w[7:0], 1'b0};
    end
  endfunction

  // Aligns a top-filled receive shifter; returns {parity error, ninth bit, data}.
  function automatic logic [9:0] suart_decode(input logic [1:0] mode, input logic pe,
                                              input logic even, input logic [8:0] sh);
    logic [8:0] a;
    a = sh >> (4'h9 - suart_pay_len(mode, pe));
    if (mode == `SUART_MODE_U7) begin
      suart_decode = {pe & ((^a[7:0]) == even), 2'h0, a[6:0]};
    end else if (mode == `SUART_MODE_U8) begin
      suart_decode = {pe & ((^a[8:0]) == even), 1'b0, a[7:0]};
    end else begin
      suart_decode = {1'b0, a};
    end
  endfunction
endpackage

// ---- suart_if.sv ----
`timescale 1ns/1ps
interface suart_if;
  logic sclk_dev_o;
  logic sclk_dev_oe;
  logic sclk_host_o;
  logic sclk_host_oe;
  logic dev_txd;
  logic host_txd;
  logic sclk;
  // The shift clock line idles high when neither end drives it.
  assign sclk = sclk_dev_oe ? sclk_dev_o : (sclk_host_oe ? sclk_host_o : 1'b1);
  modport dev (input sclk, input host_txd, output sclk_dev_o, output sclk_dev_oe,
               output dev_txd);
  modport host (input sclk, input dev_txd, output sclk_host_o, output sclk_host_oe,
                output host_txd);
endinterface

// ---- suart_fifo.sv ----
`timescale 1ns/1ps
module suart_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  // Clock, reset and clock enable.
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Fill side.
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side.
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW:0] wp_r, rp_r, wp_nxt, rp_nxt;
  logic full, empty;

  assign empty = wp_r == rp_r;
  assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem_r[rp_r[AW-1:0]];

  always_comb begin
    wp_nxt = wp_r + {{AW{1'b0}}, (in_valid_in && !full)};
    rp_nxt = rp_r + {{AW{1'b0}}, (out_ready_in && !empty)};
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wp_r <= '0;
      rp_r <= '0;
    end else if (ce_in) begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      if (in_valid_in && !full) begin
        mem_r[wp_r[AW-1:0]] <= in_data_in;
      end
    end
  end
endmodule

// ---- suart_host.sv ----
`timescale 1ns/1ps
`include "suart_regs.svh"
module suart_host (
  // Clock, reset and clock enable.
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Link.
  suart_if.host link,
  // Configuration.
  input wire logic [1:0] mode_selection_field_in,
  input wire logic clk_out_mode_in,
  input wire logic parity_enable_bit_in,
  input wire logic parity_even_in,
  input wire logic stop_length_setting_in,
  // Send side.
  input wire logic send_in,
  input wire logic [8:0] send_word_in,
  output logic send_busy_out,
  // Receive side.
  output logic [8:0] recv_word_out,
  output logic recv_valid_out
);
  logic sclk_s1_r, sclk_s2_r, sclk_s3_r, rxd_s1_r, rxd_s2_r;
  logic [11:0] ser_r, ser_nxt;
  logic [8:0] rsh_r, rsh_nxt, word_r, word_nxt;
  logic txd_r, txd_nxt, sclk_r, sclk_nxt, act_r, act_nxt, vld_r, vld_nxt;
  logic [3:0] cnt_r, cnt_nxt, rcnt_r, rcnt_nxt;
  logic [15:0] div_r, div_nxt, rdiv_r, rdiv_nxt;
  suart_pkg::suart_rx_e st_r, st_nxt;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sclk_s1_r <= 1'b1;
      sclk_s2_r <= 1'b1;
      sclk_s3_r <= 1'b1;
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
    end else if (ce_in) begin
      sclk_s1_r <= link.sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      rxd_s1_r <= link.dev_txd;
      rxd_s2_r <= rxd_s1_r;
    end
  end

  always_comb begin
    logic io, fall, rise;
    logic [3:0] plen;
    logic [9:0] dec;
    io = mode_selection_field_in == `SUART_MODE_IO;
    plen = suart_pkg::suart_pay_len(mode_selection_field_in, parity_enable_bit_in);
    dec = suart_pkg::suart_decode(mode_selection_field_in, parity_enable_bit_in,
                                  parity_even_in, rsh_r);
    fall = sclk_s3_r && !sclk_s2_r;
    rise = !sclk_s3_r && sclk_s2_r;
    ser_nxt = ser_r;
    rsh_nxt = rsh_r;
    word_nxt = word_r;
    txd_nxt = txd_r;
    sclk_nxt = sclk_r;
    act_nxt = act_r;
    vld_nxt = 1'b0;
    cnt_nxt = cnt_r;
    rcnt_nxt = rcnt_r;
    div_nxt = div_r;
    rdiv_nxt = rdiv_r + 16'h0001;
    st_nxt = st_r;
    if (io && clk_out_mode_in) begin
      fall = 1'b0;
      rise = 1'b0;
      if (act_r && div_r == `SUART_HOST_HALF - 16'h0001) begin
        div_nxt = 16'h0000;
        sclk_nxt = !sclk_r;
        fall = sclk_r;
        rise = !sclk_r;
      end else if (act_r) begin
        div_nxt = div_r + 16'h0001;
      end
    end
    // The next byte must be loaded before the far end starts the next frame.
    if (send_in && !act_r) begin
      ser_nxt = io ? {4'hf, send_word_in[7:0]}
                   : suart_pkg::suart_frame(mode_selection_field_in, parity_enable_bit_in,
                                            parity_even_in, send_word_in);
      txd_nxt = ser_nxt[0];
      act_nxt = !io || clk_out_mode_in;
      cnt_nxt = 4'h0;
      div_nxt = 16'h0000;
      sclk_nxt = 1'b1;
    end else if (io) begin
      // Between frames the line shows the armed first bit, or idle after a frame.
      if (!act_r) begin
        txd_nxt = ser_r[0];
      end
      if (fall && !act_r) begin
        act_nxt = 1'b1;
        cnt_nxt = 4'h0;
      end else if (fall && cnt_r != 4'h0) begin
        ser_nxt = {1'b1, ser_r[11:1]};
        txd_nxt = ser_r[1];
      end
      if (rise && act_r) begin
        rsh_nxt = {rxd_s2_r, rsh_r[8:1]};
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == `SUART_IO_BITS - 4'h1) begin
          act_nxt = 1'b0;
          ser_nxt = 12'hfff;
          word_nxt = {1'b0, rxd_s2_r, rsh_r[8:2]};
          vld_nxt = 1'b1;
        end
      end
    end else if (act_r) begin
      if (div_r == `SUART_BIT_CYC - 16'h0001) begin
        div_nxt = 16'h0000;
        ser_nxt = {1'b1, ser_r[11:1]};
        txd_nxt = ser_r[1];
        cnt_nxt = cnt_r + 4'h1;
        act_nxt = cnt_r != plen + 4'h1 + {3'h0, stop_length_setting_in};
      end else begin
        div_nxt = div_r + 16'h0001;
      end
    end
    unique case (st_r)
      suart_pkg::SUART_RX_IDLE: begin
        rdiv_nxt = 16'h0000;
        if (!io && !rxd_s2_r) begin
          st_nxt = suart_pkg::SUART_RX_START;
        end
      end
      suart_pkg::SUART_RX_START: begin
        if (rdiv_r == `SUART_HALF_BIT - 16'h0001) begin
          rdiv_nxt = 16'h0000;
          rcnt_nxt = 4'h0;
          st_nxt = rxd_s2_r ? suart_pkg::SUART_RX_IDLE : suart_pkg::SUART_RX_BITS;
        end
      end
      suart_pkg::SUART_RX_BITS: begin
        if (rdiv_r == `SUART_BIT_CYC - 16'h0001) begin
          rdiv_nxt = 16'h0000;
          rsh_nxt = {rxd_s2_r, rsh_r[8:1]};
          rcnt_nxt = rcnt_r + 4'h1;
          if (rcnt_r == plen - 4'h1) begin
            st_nxt = suart_pkg::SUART_RX_STOP;
          end
        end
      end
      suart_pkg::SUART_RX_STOP: begin
        if (rdiv_r == `SUART_BIT_CYC - 16'h0001) begin
          st_nxt = suart_pkg::SUART_RX_IDLE;
          word_nxt = dec[8:0];
          vld_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ser_r <= 12'hfff;
      rsh_r <= 9'h000;
      word_r <= 9'h000;
      txd_r <= 1'b1;
      sclk_r <= 1'b1;
      act_r <= 1'b0;
      vld_r <= 1'b0;
      cnt_r <= 4'h0;
      rcnt_r <= 4'h0;
      div_r <= 16'h0000;
      rdiv_r <= 16'h0000;
      st_r <= suart_pkg::SUART_RX_IDLE;
    end else if (ce_in) begin
      ser_r <= ser_nxt;
      rsh_r <= rsh_nxt;
      word_r <= word_nxt;
      txd_r <= txd_nxt;
      sclk_r <= sclk_nxt;
      act_r <= act_nxt;
      vld_r <= vld_nxt;
      cnt_r <= cnt_nxt;
      rcnt_r <= rcnt_nxt;
      div_r <= div_nxt;
      rdiv_r <= rdiv_nxt;
      st_r <= st_nxt;
    end
  end

  assign link.host_txd = txd_r;
  assign link.sclk_host_o = sclk_r;
  assign link.sclk_host_oe = clk_out_mode_in && mode_selection_field_in == `SUART_MODE_IO;
  assign send_busy_out = act_r;
  assign recv_word_out = word_r;
  assign recv_valid_out = vld_r;
endmodule

// ---- suart_asserts.sv ----
`timescale 1ns/1ps
module suart_asserts (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Link signals.
  input wire logic sclk_dev_o,
  input wire logic sclk_dev_oe,
  input wire logic sclk_host_o,
  input wire logic sclk_host_oe,
  input wire logic dev_txd,
  input wire logic host_txd,
  input wire logic sclk
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  wire async_w = !sclk_dev_oe && !sclk_host_oe;
  a_one_driver: assert property (!(sclk_dev_oe && sclk_host_oe))
    else $error("both ends drive the shift clock");
  a_rst_idle: assert property ($rose(rst_n_in) |-> dev_txd && host_txd && sclk)
    else $error("link not idle after reset");
  a_dev_low_half: assert property (sclk_dev_oe && $fell(sclk_dev_o) |-> ##15 !sclk_dev_o ##1 sclk_dev_o)
    else $error("device clock low phase wrong");
  a_host_low_half: assert property (sclk_host_oe && $fell(sclk_host_o) |-> ##11 !sclk_host_o ##1 sclk_host_o)
    else $error("host clock low phase wrong");
  a_dev_hold_rise: assert property ($rose(sclk) |-> $stable(dev_txd))
    else $error("device data moved at sampling edge");
  a_host_hold_rise: assert property ($rose(sclk) |-> $stable(host_txd))
    else $error("host data moved at sampling edge");
  a_dev_bit_len: assert property (async_w && $fell(dev_txd) |-> !dev_txd [*8])
    else $error("device low bit too short");
  a_host_bit_len: assert property (async_w && $rose(host_txd) |-> host_txd [*8])
    else $error("host high bit too short");
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
`include "suart_regs.svh"
module tb;
  logic mclk_in = 0, rst_n_in = 0, ce_in = 1, clk_out_mode_in = 0, receive_enable_bit_in = 0;
  logic transmit_enable_in = 0, double_buffer_select_in = 0, parity_enable_bit_in = 0;
  logic parity_even_in = 0, stop_length_setting_in = 0, wake_up_bit_in = 0;
  logic transmit_ninth_bit_in = 0, tx_valid_in = 0, rx_read_in = 0, send_in = 0;
  logic [1:0] mode_selection_field_in = 2'h2;
  logic [7:0] tx_data_in = 8'h00, rx_data_out;
  logic [8:0] send_word_in = 9'h000, recv_word_out, w, mk;
  logic tx_ready_out, receive_ninth_bit_out, receive_buffer_full_flag_out, send_busy_out;
  logic transmit_buffer_empty_flag_out, receive_interrupt_out, transmit_interrupt_out;
  logic overrun_out, underrun_out, parity_err_out, framing_err_out, recv_valid_out;
  int mismatches = 0, total_checks = 0, cyc = 0;
  wire [4:0] ev = {overrun_out, underrun_out, transmit_interrupt_out, receive_interrupt_out,
                   recv_valid_out};
  suart_if lk ();
  suart_dev suart_dev_i (.link(lk), .*);
  suart_host suart_host_i (.link(lk), .clk_out_mode_in(!clk_out_mode_in), .*);
  suart_asserts suart_asserts_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .sclk_dev_o(lk.sclk_dev_o), .sclk_dev_oe(lk.sclk_dev_oe), .sclk_host_o(lk.sclk_host_o),
    .sclk_host_oe(lk.sclk_host_oe), .dev_txd(lk.dev_txd), .host_txd(lk.host_txd), .sclk(lk.sclk));
  always #2.5 mclk_in = ~mclk_in;
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches = mismatches + 1;
      finish_test();
    end
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Waits for one event pulse, sampled just after the clock edge.
  task automatic wt(input int k);
    int n;
    n = 0;
    do begin
      @(posedge mclk_in);
      #1 n++;
    end while (!ev[k] && n < 3000);
    chk({8'h00, ev[k]}, 9'h001);
  endtask
  task automatic rdx;
    @(negedge mclk_in);
    rx_read_in = 1;
    @(negedge mclk_in);
    rx_read_in = 0;
  endtask
  task automatic put(input logic [7:0] d, input logic n9);
    @(negedge mclk_in);
    tx_data_in = d;
    transmit_ninth_bit_in = n9;
    tx_valid_in = 1;
    @(negedge mclk_in);
    tx_valid_in = 0;
  endtask
  task automatic hs(input logic [8:0] v);
    @(negedge mclk_in);
    while (send_busy_out !== 1'b0) @(negedge mclk_in);
    send_word_in = v;
    send_in = 1;
    @(negedge mclk_in);
    send_in = 0;
  endtask
  initial begin
    repeat (10) @(negedge mclk_in);
    rst_n_in = 1;
    @(negedge mclk_in);
    chk({7'h00, tx_ready_out, transmit_buffer_empty_flag_out}, 9'h003);
    receive_enable_bit_in = 1;
    transmit_enable_in = 1;
    for (int m = 1; m < 4; m++) begin
      repeat (200) @(negedge mclk_in);
      mode_selection_field_in = m[1:0];
      parity_enable_bit_in = (m != 3);
      parity_even_in = m[0];
      stop_length_setting_in = m[1];
      mk = (m == 1) ? 9'h07f : (m == 2) ? 9'h0ff : 9'h1ff;
      w = (m == 1) ? 9'h05a : 9'h1a5;
      hs(w);
      wt(1);
      chk({receive_ninth_bit_out, rx_data_out} & mk, w & mk);
      chk({8'h00, receive_buffer_full_flag_out}, 9'h001);
      rdx();
      chk({8'h00, receive_buffer_full_flag_out}, 9'h000);
      put(w[7:0], w[8]);
      wt(2);
      wt(0);
      chk(recv_word_out & mk, w & mk);
      $display("async test %0d done", m);
    end
    wake_up_bit_in = 1;
    hs(9'h033);
    hs(9'h1c3);
    wt(1);
    chk({receive_ninth_bit_out, rx_data_out}, 9'h1c3);
    rdx();
    $display("wake-up test done");
    repeat (200) @(negedge mclk_in);
    wake_up_bit_in = 0;
    mode_selection_field_in = `SUART_MODE_IO;
    clk_out_mode_in = 1;
    hs(9'h03c);
    put(8'h96, 1'b0);
    wt(1);
    chk({1'b0, rx_data_out}, 9'h03c);
    repeat (40) @(negedge mclk_in);
    chk({1'b0, recv_word_out[7:0]}, 9'h096);
    rdx();
    $display("clock-out test done");
    repeat (100) @(negedge mclk_in);
    clk_out_mode_in = 0;
    hs(9'h0c3);
    wt(3);
    wt(1);
    chk({1'b0, rx_data_out}, 9'h0c3);
    repeat (40) @(negedge mclk_in);
    chk({1'b0, recv_word_out[7:0]}, 9'h0ff);
    hs(9'h055);
    wt(4);
    chk({1'b0, rx_data_out}, 9'h0c3);
    $display("clock-in test done");
    finish_test();
  end
endmodule
